// ==== logic/irs_top.sv ====
// i2c target giving an external host access to the internal registers
`timescale 1ns/1ps
// Summary of operation
// - Answer as a slave to one 7-bit target address at standard and fast bus rates.
// - Keep an 8-bit pointer naming the register for the next data byte.
// - Advance the pointer by one after every acknowledged write data byte and every byte fetched for a read.
// - Keep the pointer through STOP and idle bus time for the next transaction.
// - A read after a read continues one past the last byte returned.
// - Drive ACK or NACK on the ninth clock after every byte received in a write.
// - The host ends a read by NACK then STOP, and the slave releases the data line.
// - After a read, a read with no pointer byte is served from the kept pointer.
module irs_top
  import irs_pkg::*;
#(
  parameter logic [ADDR_W-1:0] DEV_ADDR = DEV_ADDR_DFLT
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              en,
  input  wire logic              link_clk,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output irs_wr_t                wr,
  output logic                   rd_req,
  output logic [PTR_W-1:0]       rd_addr,
  input  wire logic              rd_valid,
  input  wire logic [DATA_W-1:0] rd_data
);
  // ---------------- link domain ----------------
  logic [2:0]        scl_sy;
  logic [2:0]        sda_sy;
  logic [1:0]        en_sy;
  logic [1:0]        ack_sy;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              busy;
  irs_state_t        st_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [7:0]        shreg_q;
  logic [PTR_W-1:0]  ptr_q;
  logic              rw_q;
  logic              first_q;
  logic              ack_ok_q;
  logic              mack_q;
  logic              issued_q;
  logic              sda_oe_q;
  logic              scl_oe_q;
  logic              req_tog_q;
  irs_req_t          req_q;
  // ---------------- system domain ----------------
  logic [1:0]        rq_sy;
  logic              ack_tog_q;
  logic              pend;
  logic              rd_wait_q;
  logic              rd_req_q;
  logic [PTR_W-1:0]  rd_addr_q;
  logic [DATA_W-1:0] rd_hold_q;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [WR_W-1:0]   fifo_out;

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

  // stage [0] feeds only stage [1]; stage [2] is the previous synced sample
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_sy <= 3'b111;
      sda_sy <= 3'b111;
      en_sy  <= 2'b00;
      ack_sy <= 2'b00;
    end else begin
      scl_sy <= {scl_sy[1:0], scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      en_sy  <= {en_sy[0], en};
      ack_sy <= {ack_sy[0], ack_tog_q};
    end
  end

  assign scl_rise = scl_sy[1] && !scl_sy[2];
  assign scl_fall = !scl_sy[1] && scl_sy[2];
  assign start_c  = scl_sy[1] && scl_sy[2] && sda_sy[2] && !sda_sy[1];
  assign stop_c   = scl_sy[1] && scl_sy[2] && !sda_sy[2] && sda_sy[1];
  // a request still in flight to the system side
  assign busy     = req_tog_q != ack_sy[1];

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      st_q      <= ST_IDLE;
      cnt_q     <= CNT_RST;
      shreg_q   <= BYTE_RST;
      ptr_q     <= PTR_RST;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      ack_ok_q  <= 1'b0;
      mack_q    <= 1'b0;
      issued_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      scl_oe_q  <= 1'b0;
      req_tog_q <= 1'b0;
      req_q     <= '0;
    end else if (en_sy[1]) begin
      if (start_c) begin
        st_q     <= ST_ADDR;
        cnt_q    <= CNT_RST;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
      end else if (stop_c) begin
        // pointer is left untouched across stop and idle time
        st_q     <= ST_IDLE;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_sy[1]};
              cnt_q   <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
              if (shreg_q[7:1] == DEV_ADDR) begin
                rw_q     <= shreg_q[0];
                first_q  <= !shreg_q[0];
                ack_ok_q <= 1'b1;
                sda_oe_q <= 1'b1;
                st_q     <= ST_ACK;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              cnt_q    <= CNT_RST;
              if (!ack_ok_q) begin
                st_q <= ST_IDLE;
              end else if (rw_q) begin
                // hold scl low until the byte has been fetched
                st_q     <= ST_FETCH;
                scl_oe_q <= 1'b1;
                issued_q <= 1'b0;
              end else begin
                st_q <= ST_WBYTE;
              end
            end
          end
          ST_WBYTE: begin
            if (scl_rise) begin
              shreg_q <= {shreg_q[6:0], sda_sy[1]};
              cnt_q   <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
              st_q <= ST_ACK;
              if (first_q) begin
                ptr_q    <= shreg_q;
                first_q  <= 1'b0;
                ack_ok_q <= 1'b1;
                sda_oe_q <= 1'b1;
              end else if (!busy) begin
                req_q     <= '{rd: 1'b0, addr: ptr_q, data: shreg_q};
                req_tog_q <= !req_tog_q;
                ptr_q     <= ptr_q + PTR_STEP;
                ack_ok_q  <= 1'b1;
                sda_oe_q  <= 1'b1;
              end else begin
                // previous byte not yet taken: refuse this one with a nack
                ack_ok_q <= 1'b0;
              end
            end
          end
          ST_FETCH: begin
            if (!busy) begin
              if (!issued_q) begin
                req_q     <= '{rd: 1'b1, addr: ptr_q, data: BYTE_RST};
                req_tog_q <= !req_tog_q;
                issued_q  <= 1'b1;
              end else begin
                shreg_q  <= rd_hold_q;
                ptr_q    <= ptr_q + PTR_STEP;
                scl_oe_q <= 1'b0;
                sda_oe_q <= !rd_hold_q[7];
                cnt_q    <= CNT_RST;
                st_q     <= ST_RBYTE;
              end
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == LAST_TX_BIT) begin
                sda_oe_q <= 1'b0;
                st_q     <= ST_RACK;
              end else begin
                shreg_q  <= {shreg_q[6:0], 1'b0};
                sda_oe_q <= !shreg_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= !sda_sy[1];
            end else if (scl_fall) begin
              if (mack_q) begin
                st_q     <= ST_FETCH;
                scl_oe_q <= 1'b1;
                issued_q <= 1'b0;
              end else begin
                // host nack: line already released, wait for stop
                st_q <= ST_IDLE;
              end
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------- system side of the handshake ----------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rq_sy <= 2'b00;
    end else begin
      rq_sy <= {rq_sy[0], req_tog_q};
    end
  end

  // req_q is stable while a toggle is pending, so it is read directly
  assign pend          = rq_sy[1] != ack_tog_q;
  assign fifo_in_valid = en && pend && !req_q.rd;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_tog_q <= 1'b0;
      rd_wait_q <= 1'b0;
      rd_req_q  <= 1'b0;
      rd_addr_q <= PTR_RST;
      rd_hold_q <= BYTE_RST;
    end else if (en) begin
      rd_req_q <= 1'b0;
      if (fifo_in_valid && fifo_in_ready) begin
        ack_tog_q <= !ack_tog_q;
      end
      // reads wait for queued writes to drain so they never see stale data
      if (pend && req_q.rd && !rd_wait_q && !wr_valid) begin
        rd_req_q  <= 1'b1;
        rd_addr_q <= req_q.addr;
        rd_wait_q <= 1'b1;
      end
      if (rd_wait_q && rd_valid) begin
        rd_hold_q <= rd_data;
        rd_wait_q <= 1'b0;
        ack_tog_q <= !ack_tog_q;
      end
    end
  end

  assign rd_req  = rd_req_q;
  assign rd_addr = rd_addr_q;
  assign wr      = irs_wr_t'(fifo_out);

  irs_fifo #(
    .WIDTH (WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .nrst      (nrst),
    .en        (en),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({req_q.addr, req_q.data}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  // ---------------- checks ----------------
  addr_miss_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (en_sy[1] && !start_c && !stop_c && st_q == ST_ADDR && scl_fall
     && cnt_q == BITS_PER_BYTE && shreg_q[7:1] != DEV_ADDR)
    |=> (st_q == ST_IDLE && !sda_oe_q))
    else $error("foreign address was answered");
  ptr_load_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (en_sy[1] && !start_c && !stop_c && st_q == ST_WBYTE && scl_fall
     && cnt_q == BITS_PER_BYTE && first_q)
    |=> (ptr_q == $past(shreg_q) && sda_oe_q && st_q == ST_ACK))
    else $error("pointer not loaded from first write byte");
  ptr_step_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (en_sy[1] && !start_c && !stop_c && st_q == ST_FETCH && issued_q && !busy)
    |=> (ptr_q == $past(ptr_q) + PTR_STEP && st_q == ST_RBYTE && !scl_oe_q))
    else $error("pointer not advanced after read byte");
  ptr_idle_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (st_q == ST_IDLE) |=> $stable(ptr_q))
    else $error("pointer changed while bus idle");
  rd_addr_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (en_sy[1] && !start_c && !stop_c && st_q == ST_FETCH && !issued_q && !busy)
    |=> (req_q.rd && req_q.addr == $past(ptr_q) && busy))
    else $error("read fetched from wrong location");
  wr_ack_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (en_sy[1] && !start_c && !stop_c && st_q == ST_WBYTE && scl_fall
     && cnt_q == BITS_PER_BYTE && !first_q)
    |=> (st_q == ST_ACK && sda_oe_q == $past(!busy) && ack_ok_q == $past(!busy)))
    else $error("write byte ack does not follow buffer state");
  nack_rel_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (en_sy[1] && !start_c && !stop_c && st_q == ST_RACK && scl_fall && !mack_q)
    |=> (!sda_oe_q && !scl_oe_q && st_q == ST_IDLE))
    else $error("data line held after host nack");
  stretch_a: assert property (@(posedge link_clk) disable iff (!nrst)
    (st_q == ST_FETCH) |-> (scl_oe_q && !sda_oe_q))
    else $error("clock not held during fetch");
  wr_push_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fifo_in_valid && fifo_in_ready) |=> (ack_tog_q != $past(ack_tog_q)) ##1 !pend)
    else $error("stored write not acknowledged to link");

  wr_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst) wr_valid && wr_ready);
  rd_seen_c: cover property (@(posedge link_clk) disable iff (!nrst)
    st_q == ST_FETCH ##1 st_q == ST_RBYTE);
  nack_seen_c: cover property (@(posedge link_clk) disable iff (!nrst)
    st_q == ST_ACK && !ack_ok_q);
endmodule

// ==== logic/irs_pkg.sv ====
// shared constants, states and carrier types of the i2c register access slave
package irs_pkg;
  localparam int         ADDR_W        = 7;
  localparam int         PTR_W         = 8;
  localparam int         DATA_W        = 8;
  localparam int         FIFO_DEPTH    = 4;
  localparam int         CNT_W         = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;
  localparam logic [3:0] CNT_RST       = 4'h0;
  localparam logic [7:0] PTR_RST       = 8'h00;
  localparam logic [7:0] PTR_STEP      = 8'h01;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  // target address default is arbitrary
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_ACK   = 7'b000_0100,
    ST_WBYTE = 7'b000_1000,
    ST_FETCH = 7'b001_0000,
    ST_RBYTE = 7'b010_0000,
    ST_RACK  = 7'b100_0000
  } irs_state_t;

  typedef struct packed {
    logic             rd;
    logic [PTR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } irs_req_t;

  typedef struct packed {
    logic [PTR_W-1:0]  addr;
    logic [DATA_W-1:0] data;
  } irs_wr_t;

  localparam int WR_W = PTR_W + DATA_W;
endpackage

// ==== logic/irs_fifo.sv ====
// small synchronous fifo for register writes
`timescale 1ns/1ps
module irs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty     = (wp_q == rp_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = en && in_valid && !full;
  assign pop       = en && out_ready && !empty;
  assign out_data  = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

// ==== tb/irs_host_model.sv ====
// i2c bus master model driving the open-drain clock and data lines
`timescale 1ns/1ps
module irs_host_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  realtime thalf = 1300.0;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // data moves a quarter of thalf after the clock falls, so the target never sees a false start
  task automatic bit_xfer(input logic b, output logic smp);
    #(thalf / 4) sda_low = !b;
    #(thalf) scl_low = 1'b0;
    // target may stretch the clock while it fetches a byte
    wait (scl === 1'b1);
    #(thalf / 2) smp = sda;
    #(thalf / 2) scl_low = 1'b1;
  endtask

  task automatic start_cond();
    #(thalf / 4) sda_low = 1'b0;
    #(thalf) scl_low = 1'b0;
    wait (scl === 1'b1);
    #(thalf) sda_low = 1'b1;
    #(thalf) scl_low = 1'b1;
  endtask

  task automatic stop_cond();
    #(thalf / 4) sda_low = 1'b1;
    #(thalf) scl_low = 1'b0;
    wait (scl === 1'b1);
    #(thalf) sda_low = 1'b0;
    #(thalf);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, nak);
  endtask

  task automatic rbyte(output logic [7:0] b, input logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(nak, s);
  endtask
endmodule

// ==== tb/irs_top_tb_top.sv ====
// testbench for the i2c register access slave
`timescale 1ns/1ps
module irs_top_tb_top;
  import irs_pkg::*;
  logic       sys_clk, link_clk, nrst, en, wr_ready, rd_valid;
  logic       scl_oe, sda_oe, wr_valid, rd_req, h_scl_low, h_sda_low, scl_w, sda_w;
  logic       scl_o, sda_o;
  logic [7:0] rd_data, rd_addr, rd_a;
  logic [7:0] mem [256];
  irs_wr_t    wr;
  int         failures, checked, cycles, rd_wait, rd_lat;
  localparam logic [7:0] AW = {DEV_ADDR_DFLT, 1'b0};
  localparam logic [7:0] AR = {DEV_ADDR_DFLT, 1'b1};

  assign scl_w = !(scl_oe || h_scl_low);
  assign sda_w = !(sda_oe || h_sda_low);

  irs_top #(.DEV_ADDR(DEV_ADDR_DFLT)) irs_top_i (
    .sys_clk(sys_clk), .nrst(nrst), .en(en), .link_clk(link_clk),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));

  irs_host_model irs_host_model_i (
    .scl(scl_w), .sda(sda_w), .scl_low(h_scl_low), .sda_low(h_sda_low));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  // register file on the system side; read latency alternates fast and slow
  always @(posedge sys_clk) begin
    // a pop needs the clock enable as well
    if (wr_valid === 1'b1 && wr_ready === 1'b1 && en === 1'b1) mem[wr.addr] = wr.data;
    if (rd_req === 1'b1) begin
      rd_a = rd_addr;
      rd_wait = rd_lat;
      rd_lat = (rd_lat == 1) ? 6 : 1;
    end
    #1;
    rd_valid = 1'b0;
    rd_data = ~rd_data;
    if (rd_wait > 0) begin
      rd_wait--;
      if (rd_wait == 0) begin
        rd_valid = 1'b1;
        rd_data = mem[rd_a];
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_nak, input string what);
    logic nak;
    irs_host_model_i.wbyte(b, nak);
    chk(what, {7'h00, exp_nak}, {7'h00, nak});
  endtask

  task automatic recv(input logic nak, input logic [7:0] exp, input string what);
    logic [7:0] b;
    irs_host_model_i.rbyte(b, nak);
    chk(what, exp, b);
  endtask

  task automatic drain();
    for (int i = 0; i < 200 && wr_valid !== 1'b0; i++) @(posedge sys_clk);
    chk("wr_valid drained", 8'h00, {7'h00, wr_valid});
  endtask

  task automatic t_power_read();
    irs_host_model_i.start_cond();
    send(AR, 1'b0, "addr read ack");
    recv(1'b1, 8'h5a, "read from reset pointer");
    chk("open drain level", 8'h00, {6'h00, scl_o, sda_o});
    irs_host_model_i.stop_cond();
  endtask

  task automatic t_write_wrap();
    irs_host_model_i.start_cond();
    send(AW, 1'b0, "addr write ack");
    send(8'hfe, 1'b0, "pointer ack");
    send(8'h11, 1'b0, "data0 ack");
    send(8'h22, 1'b0, "data1 ack");
    send(8'h33, 1'b0, "data2 ack");
    irs_host_model_i.stop_cond();
    drain();
    irs_host_model_i.start_cond();
    send(AW, 1'b0, "addr write ack");
    send(8'hfe, 1'b0, "pointer ack");
    irs_host_model_i.start_cond();
    send(AR, 1'b0, "addr read ack");
    recv(1'b0, 8'h11, "read fe");
    recv(1'b0, 8'h22, "read ff");
    recv(1'b1, 8'h33, "read wrapped 00");
    chk("data released", 8'h00, {7'h00, sda_oe});
    irs_host_model_i.stop_cond();
  endtask

  task automatic t_read_again();
    irs_host_model_i.start_cond();
    send(AR, 1'b0, "addr read ack");
    recv(1'b0, 8'h5b, "read continues 01");
    recv(1'b1, 8'h58, "read continues 02");
    irs_host_model_i.stop_cond();
    #20000;
    irs_host_model_i.start_cond();
    send(AR, 1'b0, "addr read ack");
    recv(1'b1, 8'h59, "pointer kept over idle");
    irs_host_model_i.stop_cond();
  endtask

  task automatic t_wrong_addr();
    irs_host_model_i.start_cond();
    send({DEV_ADDR_DFLT ^ 7'h01, 1'b0}, 1'b1, "foreign addr nack");
    irs_host_model_i.stop_cond();
  endtask

  task automatic t_fifo_full();
    wr_ready = 1'b0;
    irs_host_model_i.start_cond();
    send(AW, 1'b0, "addr write ack");
    send(8'h40, 1'b0, "pointer ack");
    // four bytes fill the fifo, a fifth waits in the link's request register
    for (int i = 0; i < 5; i++) send(8'h80 + 8'(i), 1'b0, "queued data ack");
    send(8'h85, 1'b1, "full fifo nack");
    irs_host_model_i.stop_cond();
    chk("stalled valid", 8'h01, {7'h00, wr_valid});
    chk("stalled addr", 8'h40, wr.addr);
    @(posedge sys_clk);
    #1 en = 1'b0;
    wr_ready = 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("frozen valid", 8'h01, {7'h00, wr_valid});
    chk("frozen addr", 8'h40, wr.addr);
    #1 en = 1'b1;
    drain();
    for (int i = 0; i < 5; i++) chk("stored byte", 8'h80 + 8'(i), mem[8'h40 + 8'(i)]);
    chk("refused byte not stored", 8'h1f, mem[8'h45]);
    irs_host_model_i.start_cond();
    send(AR, 1'b0, "addr read ack");
    recv(1'b1, 8'h1f, "pointer after refusal");
    irs_host_model_i.stop_cond();
  endtask

  task automatic t_std_mode();
    irs_host_model_i.thalf = 5000.0;
    irs_host_model_i.start_cond();
    send(AW, 1'b0, "slow addr ack");
    send(8'h10, 1'b0, "slow pointer ack");
    send(8'hc3, 1'b0, "slow data ack");
    irs_host_model_i.stop_cond();
    drain();
    irs_host_model_i.start_cond();
    send(AW, 1'b0, "slow addr ack");
    send(8'h10, 1'b0, "slow pointer ack");
    irs_host_model_i.start_cond();
    send(AR, 1'b0, "slow addr read ack");
    recv(1'b1, 8'hc3, "slow read back");
    irs_host_model_i.stop_cond();
    irs_host_model_i.thalf = 1300.0;
  endtask

  initial begin
    nrst = 1'b0;
    en = 1'b1;
    wr_ready = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    rd_lat = 1;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (20) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (10) @(posedge sys_clk);
    t_power_read();
    t_write_wrap();
    t_read_again();
    t_wrong_addr();
    t_fifo_full();
    t_std_mode();
    report_and_stop();
  end
endmodule
